// >>> src/sss_sched.sv
// slow-channel message scheduler with AXI4-Lite registers
// assumes payload inputs and msg_ready come from logic on aclk
// Function
// - fail flags, id 01, every fourth slot
// - excitation code, id 83, upper nibble zero
// - user id is page times 16 plus index
// - slots 19,20,23,24 send page-three words
// - slots 27,28,31 send page-four words
// - amplitude, id 85, bits 16 to 5
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sss_sched
  import sss_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // payload sources
  input  wire logic [8:0]  fail_flags,
  input  wire logic [11:0] temp_code,
  input  wire logic [7:0]  excite_code,
  input  wire logic [16:0] rx_amp,
  // transmitter side
  input  wire logic        msg_ready,
  output logic             msg_valid,
  output logic [7:0]       msg_id,
  output logic [11:0]      msg_data,
  output logic [4:0]       msg_slot,
  // interrupt
  output logic             irq
);
  // ==========================================================
  // register storage
  logic        ctrl_en;
  logic [11:0] page_vals;
  logic [31:0] idx_lo;
  logic [3:0]  idx_hi;
  logic [11:0] proto_rev;
  logic [11:0] part_identifier_word;
  logic [11:0] user_word [USER_N];
  logic [1:0]  irq_stat;
  logic [1:0]  irq_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  sss_state_t  state;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : merge

  // ==========================================================
  // write path: address and data taken in either order
  wire        do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire        wa_user  = wr_addr[7:6] == OFS_USER_HI && wr_addr[1:0] == 2'h0
                         && wr_addr[5:2] < 4'(USER_N);
  wire [3:0]  wa_idx   = wr_addr[5:2];
  wire        wa_hit   = wa_user || wr_addr == OFS_CTRL || wr_addr == OFS_PAGES
                         || wr_addr == OFS_IDX_LO || wr_addr == OFS_IDX_HI
                         || wr_addr == OFS_REV || wr_addr == OFS_DEVID
                         || wr_addr == OFS_IRQ_EN || wr_addr == OFS_IRQ_CL;
  wire [31:0] wr_ctrl  = merge({31'h0, ctrl_en}, wr_data, wr_strb);
  wire [31:0] wr_pages = merge({20'h0, page_vals}, wr_data, wr_strb);
  wire [31:0] wr_idxlo = merge(idx_lo, wr_data, wr_strb);
  wire [31:0] wr_idxhi = merge({28'h0, idx_hi}, wr_data, wr_strb);
  wire [31:0] wr_rev   = merge({20'h0, proto_rev}, wr_data, wr_strb);
  wire [31:0] wr_devid = merge({20'h0, part_identifier_word}, wr_data, wr_strb);
  wire [31:0] wr_irqen = merge({30'h0, irq_en}, wr_data, wr_strb);
  wire [31:0] wr_clr   = merge(32'h0, wr_data, wr_strb);
  wire        clr_hit  = do_write && wr_addr == OFS_IRQ_CL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h0;
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en              <= 1'b0;
      page_vals            <= 12'h000;
      idx_lo               <= 32'h0;
      idx_hi               <= 4'h0;
      proto_rev            <= REV_RST;
      part_identifier_word <= DEVID_RST;
      irq_en               <= 2'h0;
    end else if (do_write) begin
      if (wr_addr == OFS_CTRL)   ctrl_en              <= wr_ctrl[CTRL_EN_BIT];
      if (wr_addr == OFS_PAGES)  page_vals            <= wr_pages[11:0];
      if (wr_addr == OFS_IDX_LO) idx_lo               <= wr_idxlo;
      if (wr_addr == OFS_IDX_HI) idx_hi               <= wr_idxhi[3:0];
      if (wr_addr == OFS_REV)    proto_rev            <= wr_rev[11:0];
      if (wr_addr == OFS_DEVID)  part_identifier_word <= wr_devid[11:0];
      if (wr_addr == OFS_IRQ_EN) irq_en               <= wr_irqen[1:0];
    end
  end

  // user words: one storage entry per user slot
  logic [107:0] user_flat;
  for (genvar gk = 0; gk < USER_N; gk++) begin : g_user
    wire [31:0] wr_word = merge({20'h0, user_word[gk]}, wr_data, wr_strb);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        user_word[gk] <= 12'h000;
      end else if (do_write && wa_user && wa_idx == 4'(gk)) begin
        user_word[gk] <= wr_word[11:0];
      end
    end
    assign user_flat[12*gk +: 12] = user_word[gk];
  end

  // ==========================================================
  // read path
  wire [31:0] rd_word = s_axi_araddr[7:6] == OFS_USER_HI ? {20'h0, user_word[s_axi_araddr[5:2]]}
                      : s_axi_araddr == OFS_CTRL   ? {31'h0, ctrl_en}
                      : s_axi_araddr == OFS_PAGES  ? {20'h0, page_vals}
                      : s_axi_araddr == OFS_IDX_LO ? idx_lo
                      : s_axi_araddr == OFS_IDX_HI ? {28'h0, idx_hi}
                      : s_axi_araddr == OFS_REV    ? {20'h0, proto_rev}
                      : s_axi_araddr == OFS_DEVID  ? {20'h0, part_identifier_word}
                      : s_axi_araddr == OFS_STATUS ? {26'h0, msg_valid, msg_slot}
                      : s_axi_araddr == OFS_IRQ_ST ? {30'h0, irq_stat}
                      : s_axi_araddr == OFS_IRQ_EN ? {30'h0, irq_en} : 32'h0;
  wire ra_hit = (s_axi_araddr[7:6] == OFS_USER_HI && s_axi_araddr[1:0] == 2'h0
                 && s_axi_araddr[5:2] < 4'(USER_N))
                || (s_axi_araddr[7:6] == 2'h0 && s_axi_araddr[1:0] == 2'h0
                    && s_axi_araddr <= OFS_IRQ_EN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= ra_hit ? rd_word : 32'h0;
      s_axi_rresp   <= ra_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // scheduler: payload is frozen when the slot is offered
  wire [7:0]  sel_id;
  wire [11:0] sel_data;
  sss_slot_mux u_mux (
    .slot                 (msg_slot),
    .fail_flags           (fail_flags),
    .temp_code            (temp_code),
    .excite_code          (excite_code),
    .rx_amp               (rx_amp),
    .proto_rev            (proto_rev),
    .part_identifier_word (part_identifier_word),
    .page_vals            (page_vals),
    .slot_index           ({idx_hi, idx_lo}),
    .user_flat            (user_flat),
    .msg_id               (sel_id),
    .msg_data             (sel_data)
  );

  wire msg_take   = msg_valid && msg_ready;
  wire next_slot_wrap = msg_take && msg_slot == SLOT_LAST;
  wire [4:0] next_slot = next_slot_wrap ? SLOT_FIRST : msg_slot + 5'h01;
  wire fault_evt  = msg_take && msg_id == ID_FAIL && |msg_data[8:0];
  wire [1:0] next_irq_stat = (irq_stat & ~(clr_hit ? wr_clr[1:0] : 2'h0))
                             | {fault_evt, next_slot_wrap};  // set wins over clear

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= SSS_IDLE;
      msg_valid <= 1'b0;
      msg_id    <= 8'h00;
      msg_data  <= 12'h000;
      msg_slot  <= SLOT_FIRST;
      irq_stat  <= 2'h0;
      irq       <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & irq_en);
      case (state)
        SSS_IDLE: if (ctrl_en) begin
          msg_id    <= sel_id;
          msg_data  <= sel_data;
          msg_valid <= 1'b1;
          state     <= SSS_OFFER;
        end
        SSS_OFFER: if (msg_ready) begin
          msg_valid <= 1'b0;
          msg_slot  <= next_slot;
          state     <= SSS_IDLE;
        end
        default: state <= SSS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checks on offered messages
  sequence s_offer(logic [4:0] s);
    $rose(msg_valid) && msg_slot == s;
  endsequence
  sequence s_last_taken;
    msg_valid && msg_ready && msg_slot == SLOT_LAST;
  endsequence

  a_fail_payload: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(msg_valid) && msg_slot[1:0] == 2'h1
    |-> msg_id == ID_FAIL && msg_data == {3'h0, $past(fail_flags)})
    else $error("failure-flag message wrong");
  a_curr_payload: assert property (@(posedge aclk) disable iff (!aresetn)
    s_offer(5'h16) |-> msg_id == ID_CURR && msg_data == {4'h0, $past(excite_code)})
    else $error("excitation message wrong");
  a_page_two_id: assert property (@(posedge aclk) disable iff (!aresetn)
    s_offer(5'h10) |-> msg_id == {$past(page_vals[3:0]), $past(idx_lo[7:4])})
    else $error("page-two id wrong");
  a_page_three_word: assert property (@(posedge aclk) disable iff (!aresetn)
    s_offer(5'h13) |-> msg_data == $past(user_word[2])
    && msg_id == {$past(page_vals[7:4]), $past(idx_lo[11:8])})
    else $error("page-three message wrong");
  a_page_four_word: assert property (@(posedge aclk) disable iff (!aresetn)
    s_offer(5'h1F) |-> msg_data == $past(user_word[8])
    && msg_id == {$past(page_vals[11:8]), $past(idx_hi)})
    else $error("page-four message wrong");
  a_amp_payload: assert property (@(posedge aclk) disable iff (!aresetn)
    s_offer(5'h1A) |-> msg_id == ID_AMP && msg_data == $past(rx_amp[16:5]))
    else $error("amplitude message wrong");
  a_wrap_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    s_last_taken ##1 ctrl_en |-> msg_slot == SLOT_FIRST && !msg_valid
    ##1 msg_valid && msg_id == ID_FAIL)
    else $error("sequence did not restart");
endmodule : sss_sched
`default_nettype wire

// >>> src/sss_pkg.sv
// slow-channel scheduler constants: slot range, message ids, register map
// assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses
package sss_pkg;
  // ==========================================================
  // slot sequence and message identifiers
  localparam logic [4:0] SLOT_FIRST = 5'h0D;
  localparam logic [4:0] SLOT_LAST  = 5'h1F;
  localparam logic [7:0] ID_FAIL    = 8'h01;
  localparam logic [7:0] ID_REV     = 8'h06;
  localparam logic [7:0] ID_TEMP    = 8'h23;
  localparam logic [7:0] ID_CURR    = 8'h83;
  localparam logic [7:0] ID_AMP     = 8'h85;
  localparam logic [7:0] ID_DEVID   = 8'h87;
  localparam int unsigned USER_N    = 9;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PAGES  = 8'h04;
  localparam logic [7:0] OFS_IDX_LO = 8'h08;
  localparam logic [7:0] OFS_IDX_HI = 8'h0C;
  localparam logic [7:0] OFS_REV    = 8'h10;
  localparam logic [7:0] OFS_DEVID  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_ST = 8'h1C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_IRQ_CL = 8'h24;
  localparam logic [1:0] OFS_USER_HI = 2'h1;
  // ==========================================================
  // field positions and reset values
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned PG2_LSB       = 0;
  localparam int unsigned PG3_LSB       = 4;
  localparam int unsigned PG4_LSB       = 8;
  localparam int unsigned IRQ_WRAP_BIT  = 0;
  localparam int unsigned IRQ_FAULT_BIT = 1;
  localparam logic [11:0] REV_RST       = 12'h000;
  // arbitrary neutral value, software overwrites it
  localparam logic [11:0] DEVID_RST     = 12'h000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ==========================================================
  // scheduler states
  typedef enum logic [0:0] {
    SSS_IDLE  = 1'b0,
    SSS_OFFER = 1'b1
  } sss_state_t;
endpackage : sss_pkg

// >>> src/sss_slot_mux.sv
// per-slot message id and payload selection, purely combinational
// assumes all inputs are on the aclk domain
`timescale 1ns/1ps
`default_nettype none
module sss_slot_mux
  import sss_pkg::*;
(
  // slot
  input  wire logic [4:0]   slot,
  // payload sources
  input  wire logic [8:0]   fail_flags,
  input  wire logic [11:0]  temp_code,
  input  wire logic [7:0]   excite_code,
  input  wire logic [16:0]  rx_amp,
  input  wire logic [11:0]  proto_rev,
  input  wire logic [11:0]  part_identifier_word,
  input  wire logic [11:0]  page_vals,
  input  wire logic [35:0]  slot_index,
  input  wire logic [107:0] user_flat,
  // message
  output logic      [7:0]   msg_id,
  output logic      [11:0]  msg_data
);
  // ==========================================================
  // user entry k: id = page * 16 + index, payload = stored word
  wire [3:0] user_page_two_value   = page_vals[PG2_LSB +: 4];
  wire [3:0] user_page_three_value = page_vals[PG3_LSB +: 4];
  wire [3:0] user_page_four_value  = page_vals[PG4_LSB +: 4];

  function automatic logic [7:0] uid(input logic [3:0] pg, input int k);
    uid = {pg, slot_index[4*k +: 4]};
  endfunction : uid

  always_comb begin
    msg_id   = 8'h00;
    msg_data = 12'h000;
    case (slot)
      5'h0D, 5'h11, 5'h15, 5'h19, 5'h1D: begin
        msg_id   = ID_FAIL;
        msg_data = {3'h0, fail_flags};
      end
      5'h0E: begin
        msg_id   = ID_REV;
        msg_data = proto_rev;
      end
      5'h0F: begin
        msg_id   = uid(user_page_two_value, 0);
        msg_data = user_flat[0 +: 12];
      end
      5'h10: begin
        msg_id   = uid(user_page_two_value, 1);
        msg_data = user_flat[12 +: 12];
      end
      5'h12: begin
        msg_id   = ID_TEMP;
        msg_data = temp_code;
      end
      5'h13: begin
        msg_id   = uid(user_page_three_value, 2);
        msg_data = user_flat[24 +: 12];
      end
      5'h14: begin
        msg_id   = uid(user_page_three_value, 3);
        msg_data = user_flat[36 +: 12];
      end
      5'h16: begin
        msg_id   = ID_CURR;
        msg_data = {4'h0, excite_code};
      end
      5'h17: begin
        msg_id   = uid(user_page_three_value, 4);
        msg_data = user_flat[48 +: 12];
      end
      5'h18: begin
        msg_id   = uid(user_page_three_value, 5);
        msg_data = user_flat[60 +: 12];
      end
      5'h1A: begin
        msg_id   = ID_AMP;
        msg_data = rx_amp[16:5];
      end
      5'h1B: begin
        msg_id   = uid(user_page_four_value, 6);
        msg_data = user_flat[72 +: 12];
      end
      5'h1C: begin
        msg_id   = uid(user_page_four_value, 7);
        msg_data = user_flat[84 +: 12];
      end
      5'h1E: begin
        msg_id   = ID_DEVID;
        msg_data = part_identifier_word;
      end
      5'h1F: begin
        msg_id   = uid(user_page_four_value, 8);
        msg_data = user_flat[96 +: 12];
      end
      default: begin
        msg_id   = 8'h00;
        msg_data = 12'h000;
      end
    endcase
  end
endmodule : sss_slot_mux
`default_nettype wire

// >>> verification/sss_tx_model.sv
// transmitter-side consumer that takes offered slow-channel messages
// assumes msg_valid comes from the scheduler on aclk
`timescale 1ns/1ps
`default_nettype none
module sss_tx_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // message link
  input  wire logic       msg_valid,
  input  wire logic [2:0] max_wait,
  output var  logic       msg_ready
);
  // ==========================================================
  // random acceptance delay
  // ready only while an offer stands, never ahead of it
  int         seed = 80;
  logic [2:0] wait_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msg_ready <= 1'b0;
      wait_cnt  <= 3'h0;
    end else if (msg_ready && msg_valid) begin
      msg_ready <= 1'b0;
      wait_cnt  <= 3'($random(seed)) & max_wait;
    end else if (msg_valid && wait_cnt == 3'h0) begin
      msg_ready <= 1'b1;
    end else if (msg_valid) begin
      wait_cnt <= wait_cnt - 3'h1;
    end
  end
endmodule : sss_tx_model
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the slow-channel scheduler
// assumes one 20 MHz clock and a consumer model on the message link
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sss_pkg::*;
  // ==========================================================
  // stimulus and wires
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic [8:0]  ff = 9'h000;
  logic [11:0] tc = 12'h000;
  logic [7:0]  ec = 8'h00;
  logic [16:0] ra = 17'h00000;
  logic [2:0]  mw = 3'h0;
  logic [4:0]  nslot = 5'h0D;
  logic [3:0]  p2, p3, p4;
  logic [3:0]  idx [9];
  logic [11:0] usr [9];
  logic [11:0] rev, dev;
  logic [24:0] expq [$];
  int          seed = 80;
  int          bad_count = 0;
  int          n_tests = 0;
  int          takes = 0;
  wire logic        awready, wready, bvalid, arready, rvalid;
  wire logic        msg_ready, msg_valid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  msg_id;
  wire logic [11:0] msg_data;
  wire logic [4:0]  msg_slot;
  localparam logic [4:0] USLOT [9] = '{5'h0F, 5'h10, 5'h13, 5'h14, 5'h17, 5'h18, 5'h1B,
                                       5'h1C, 5'h1F};
  initial forever #25 aclk = ~aclk;
  sss_sched sss_sched_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fail_flags(ff), .temp_code(tc), .excite_code(ec),
    .rx_amp(ra), .msg_ready(msg_ready), .msg_valid(msg_valid), .msg_id(msg_id),
    .msg_data(msg_data), .msg_slot(msg_slot), .irq(irq));
  sss_tx_model sss_tx_model_i (.aclk(aclk), .aresetn(aresetn), .msg_valid(msg_valid),
    .max_wait(mw), .msg_ready(msg_ready));
  // ==========================================================
  // checking and bus tasks
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tmo(input bit late);
    if (late) begin
      bad_count++;
      $display("[FAIL] wait expected answer seen timeout");
      give_verdict();
    end
  endtask : tmo
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    tmo(n >= 200);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    tmo(n >= 200);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask : axr
  function automatic logic [24:0] exp_msg(input logic [4:0] s, input logic [8:0] f,
      input logic [11:0] t, input logic [7:0] e, input logic [16:0] r);
    int k;
    logic [3:0] p;
    case (s)
      5'h0D, 5'h11, 5'h15, 5'h19, 5'h1D: return {s, ID_FAIL, 3'h0, f};
      5'h0E: return {s, ID_REV, rev};
      5'h12: return {s, ID_TEMP, t};
      5'h16: return {s, ID_CURR, 4'h0, e};
      5'h1A: return {s, ID_AMP, r[16:5]};
      5'h1E: return {s, ID_DEVID, dev};
      default: begin
        for (k = 0; k < 8 && USLOT[k] != s; k++) ;
        p = (k < 2) ? p2 : (k < 6) ? p3 : p4;
        return {s, p, idx[k], usr[k]};
      end
    endcase
  endfunction : exp_msg
  // ==========================================================
  // source driver notes the next message, watcher compares each take
  always @(posedge aclk) begin : drive
    logic [8:0] f;
    logic [11:0] t;
    logic [7:0] e;
    logic [16:0] r;
    if (aresetn && msg_valid === 1'b1 && msg_ready === 1'b1) begin
      f = 9'($random(seed));
      t = 12'($random(seed));
      e = 8'($random(seed));
      r = 17'($random(seed));
      ff <= f;
      tc <= t;
      ec <= e;
      ra <= r;
      mw <= 3'($random(seed));
      nslot = (nslot == 5'h1F) ? 5'h0D : nslot + 5'h01;
      expq.push_back(exp_msg(nslot, f, t, e, r));
    end
  end
  always @(posedge aclk) begin : watch
    if (aresetn && msg_valid === 1'b1 && msg_ready === 1'b1) begin
      takes++;
      if (expq.size() == 0) chk("queue", 32'h1, 32'h0);
      else begin
        chk("message", 32'(expq.pop_front()),
            {7'h0, msg_slot, msg_id, msg_data});
      end
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    int n;
    logic [31:0] lo;
    logic [8:0] f;
    for (n = 0; n < 9; n++) begin
      idx[n] = 4'($random(seed));
      usr[n] = 12'($random(seed));
      // entry 8 lives in the high index register, not in nibble 0
      if (n < 8) lo[4*n +: 4] = idx[n];
    end
    {p2, p3, p4, rev, dev} = 36'($random(seed) ^ ($random(seed) << 4));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFS_CTRL, 32'h0, RESP_OKAY);
    axr(OFS_DEVID, {20'h0, DEVID_RST}, RESP_OKAY);
    // byte strobes: only byte 1 lands, the low byte keeps its reset value
    wstrb <= 4'h2;
    axw(OFS_DEVID, 32'h00000FFF, RESP_OKAY);
    wstrb <= 4'hF;
    axr(OFS_DEVID, {20'h0, 4'hF, DEVID_RST[7:0]}, RESP_OKAY);
    chk("msg_valid", 32'h0, 32'(msg_valid));
    axw(OFS_PAGES, {20'h0, p4, p3, p2}, RESP_OKAY);
    axw(OFS_IDX_LO, lo, RESP_OKAY);
    axw(OFS_IDX_HI, {28'h0, idx[8]}, RESP_OKAY);
    axw(OFS_REV, {20'h0, rev}, RESP_OKAY);
    axw(OFS_DEVID, {20'h0, dev}, RESP_OKAY);
    for (n = 0; n < 9; n++) axw(8'h40 + 8'(4 * n), {20'h0, usr[n]}, RESP_OKAY);
    axr(8'h60, {20'h0, usr[8]}, RESP_OKAY);
    axw(8'h30, 32'h1, RESP_SLVERR);
    axr(8'h30, 32'h0, RESP_SLVERR);
    f = 9'($random(seed)) | 9'h001;
    ff <= f;
    expq.push_back(exp_msg(5'h0D, f, tc, ec, ra));
    axw(OFS_CTRL, 32'h1, RESP_OKAY);
    for (n = 0; n < 3000 && takes < 40; n++) @(posedge aclk);
    tmo(n >= 3000);
    // disabling lets a standing offer finish, so drain before looking
    axw(OFS_CTRL, 32'h0, RESP_OKAY);
    repeat (20) @(posedge aclk);
    chk("msg_valid", 32'h0, 32'(msg_valid));
    chk("irq", 32'h0, 32'(irq));
    axr(OFS_STATUS, {27'h0, nslot}, RESP_OKAY);
    axr(OFS_IRQ_ST, 32'h3, RESP_OKAY);
    axw(OFS_IRQ_EN, 32'h3, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h1, 32'(irq));
    axw(OFS_IRQ_CL, 32'h3, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, 32'(irq));
    // the clear register is write-only, so a read is refused
    axr(OFS_IRQ_CL, 32'h0, RESP_SLVERR);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
